// ---- hdl/event_counter_defs.vh ----
`ifndef EVENT_COUNTER_DEFS_VH
`define EVENT_COUNTER_DEFS_VH

// Serial register addresses
`define ADDR_IN_FN_FIRST      16'h0201
`define ADDR_IN_FN_SIXTH      16'h0206
`define ADDR_OUT_FN_FIRST     16'h020D
`define ADDR_OUT_FN_FOURTH    16'h0210
`define ADDR_OUT_POLARITY     16'h0212
`define ADDR_TERMINAL_COUNT   16'h0213
`define ADDR_PRELIM_COUNT     16'h0214
`define ADDR_IN_STATE_MAP     16'h0232
`define ADDR_OUT_STATE_MAP    16'h0233
`define ADDR_RUNNING_COUNT    16'h2109

// Fieldbus object of the running count
`define FB_INDEX_COUNT        16'h2022
`define FB_SUBINDEX_COUNT     8'h02

// Function codes
`define FN_PRELIM_REACHED     8'h11
`define FN_TERMINAL_REACHED   8'h12
`define FN_COUNT_CLEAR        8'h16
`define FN_COUNT_EVENT        8'h17

// Reset values
`define RST_POLARITY          16'h0000
`define RST_COUNT_CMP         16'h0000
`define RST_FN                8'h00
`define RST_WORD              16'h0000

`define NUM_IN                6
`define NUM_OUT               4
`define IDX_EVENT_IN          5

`endif

// ---- hdl/terminal_event_counter_io.v ----
`timescale 1ns/10ps
`include "event_counter_defs.vh"

module terminal_event_counter_io (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Input terminals, asynchronous pins
  input  wire [5:0]  input_terminal,
  // Output terminals
  output reg  [3:0]  output_terminal,
  // Serial register port
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wr_data,
  output reg  [15:0] reg_rd_data,
  output reg         reg_rd_valid,
  // Fieldbus object read port
  input  wire        fb_rd_en,
  input  wire [15:0] fb_index,
  input  wire [7:0]  fb_subindex,
  output reg  [15:0] fb_rd_data,
  output reg         fb_rd_valid,
  output reg         fb_rd_error
);

  wire [5:0]  in_sync_ff;
  reg         event_prev_ff;
  reg  [15:0] polarity_ff;
  reg  [15:0] terminal_cmp_ff;
  reg  [15:0] prelim_cmp_ff;
  reg  [7:0]  in_fn_ff [0:5];
  reg  [7:0]  out_fn_ff [0:3];
  reg  [15:0] count_ff;
  reg         term_hit_ff;
  reg         prelim_hit_ff;
  reg  [15:0] nxt_count;
  reg         nxt_term_hit;
  reg         nxt_prelim_hit;
  reg         clear_req;
  wire [3:0]  out_level;
  reg  [15:0] rd_word;
  wire        count_enable;
  wire        count_event;
  wire [15:0] count_plus;
  integer     i;

  // Pins pass two flops before any logic looks at them
  pin_sync #(.WIDTH(`NUM_IN)) u_pin_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .pin_async  (input_terminal),
    .pin_synced (in_sync_ff)
  );

  // Last synced level of the event pin, so both edges can be seen
  always @(posedge ref_clk) begin
    if (rst) begin
      event_prev_ff <= 1'b0;
    end else begin
      event_prev_ff <= in_sync_ff[`IDX_EVENT_IN];
    end
  end

  assign count_enable = (terminal_cmp_ff != `RST_COUNT_CMP);
  assign count_event  = (in_fn_ff[`IDX_EVENT_IN] == `FN_COUNT_EVENT) &&
                        (in_sync_ff[`IDX_EVENT_IN] != event_prev_ff);
  assign count_plus   = count_ff + 16'h0001;

  always @* begin
    clear_req = 1'b0;
    for (i = 0; i < `IDX_EVENT_IN; i = i + 1) begin
      if ((in_fn_ff[i] == `FN_COUNT_CLEAR) && in_sync_ff[i]) begin
        clear_req = 1'b1;
      end
    end
  end

  // Clear wins over a count event in the same cycle; prelim flag holds until the cycle restarts, terminal flag until the next event
  always @* begin
    nxt_count      = count_ff;
    nxt_term_hit   = term_hit_ff;
    nxt_prelim_hit = prelim_hit_ff;
    if (clear_req) begin
      nxt_count      = `RST_WORD;
      nxt_term_hit   = 1'b0;
      nxt_prelim_hit = 1'b0;
    end else if (!count_enable) begin
      nxt_term_hit   = 1'b0;
      nxt_prelim_hit = 1'b0;
    end else if (count_event) begin
      nxt_term_hit = 1'b0;
      if (count_plus >= terminal_cmp_ff) begin
        nxt_count      = `RST_WORD;
        nxt_term_hit   = 1'b1;
        nxt_prelim_hit = 1'b0;
      end else begin
        nxt_count = count_plus;
        if (count_plus == prelim_cmp_ff) begin
          nxt_prelim_hit = 1'b1;
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      count_ff      <= `RST_WORD;
      term_hit_ff   <= 1'b0;
      prelim_hit_ff <= 1'b0;
    end else begin
      count_ff      <= nxt_count;
      term_hit_ff   <= nxt_term_hit;
      prelim_hit_ff <= nxt_prelim_hit;
    end
  end

  // Configuration writes; read-only addresses ignore writes
  always @(posedge ref_clk) begin
    if (rst) begin
      polarity_ff     <= `RST_POLARITY;
      terminal_cmp_ff <= `RST_COUNT_CMP;
      prelim_cmp_ff   <= `RST_COUNT_CMP;
      for (i = 0; i < `NUM_IN; i = i + 1) begin
        in_fn_ff[i] <= `RST_FN;
      end
      for (i = 0; i < `NUM_OUT; i = i + 1) begin
        out_fn_ff[i] <= `RST_FN;
      end
    end else if (reg_wr_en) begin
      if (reg_addr == `ADDR_OUT_POLARITY) begin
        polarity_ff <= reg_wr_data;
      end else if (reg_addr == `ADDR_TERMINAL_COUNT) begin
        terminal_cmp_ff <= reg_wr_data;
      end else if (reg_addr == `ADDR_PRELIM_COUNT) begin
        prelim_cmp_ff <= reg_wr_data;
      end else if ((reg_addr >= `ADDR_IN_FN_FIRST) && (reg_addr <= `ADDR_IN_FN_SIXTH)) begin
        in_fn_ff[reg_addr[2:0] - 3'd1] <= reg_wr_data[7:0];
      end else if ((reg_addr >= `ADDR_OUT_FN_FIRST) && (reg_addr <= `ADDR_OUT_FN_FOURTH)) begin
        out_fn_ff[reg_addr[1:0] - 2'd1] <= reg_wr_data[7:0];
      end
    end
  end

  // One drive stage per output; other function codes leave the output inactive at its polarity level
  out_drive u_out_drive_one (
    .fn_code    (out_fn_ff[0]),
    .invert     (polarity_ff[0]),
    .term_hit   (term_hit_ff),
    .prelim_hit (prelim_hit_ff),
    .level      (out_level[0])
  );

  out_drive u_out_drive_two (
    .fn_code    (out_fn_ff[1]),
    .invert     (polarity_ff[1]),
    .term_hit   (term_hit_ff),
    .prelim_hit (prelim_hit_ff),
    .level      (out_level[1])
  );

  out_drive u_out_drive_three (
    .fn_code    (out_fn_ff[2]),
    .invert     (polarity_ff[2]),
    .term_hit   (term_hit_ff),
    .prelim_hit (prelim_hit_ff),
    .level      (out_level[2])
  );

  out_drive u_out_drive_four (
    .fn_code    (out_fn_ff[3]),
    .invert     (polarity_ff[3]),
    .term_hit   (term_hit_ff),
    .prelim_hit (prelim_hit_ff),
    .level      (out_level[3])
  );

  always @(posedge ref_clk) begin
    if (rst) begin
      output_terminal <= polarity_ff[3:0];
    end else begin
      // Registered so the pins never show a decode glitch
      output_terminal <= out_level;
    end
  end

  always @* begin
    rd_word = `RST_WORD;
    if (reg_addr == `ADDR_RUNNING_COUNT) begin
      rd_word = count_ff;
    end else if (reg_addr == `ADDR_OUT_POLARITY) begin
      rd_word = polarity_ff;
    end else if (reg_addr == `ADDR_TERMINAL_COUNT) begin
      rd_word = terminal_cmp_ff;
    end else if (reg_addr == `ADDR_PRELIM_COUNT) begin
      rd_word = prelim_cmp_ff;
    end else if (reg_addr == `ADDR_IN_STATE_MAP) begin
      rd_word = {10'h000, in_sync_ff};
    end else if (reg_addr == `ADDR_OUT_STATE_MAP) begin
      rd_word = {12'h000, output_terminal ^ polarity_ff[3:0]};
    end else if ((reg_addr >= `ADDR_IN_FN_FIRST) && (reg_addr <= `ADDR_IN_FN_SIXTH)) begin
      rd_word = {8'h00, in_fn_ff[reg_addr[2:0] - 3'd1]};
    end else if ((reg_addr >= `ADDR_OUT_FN_FIRST) && (reg_addr <= `ADDR_OUT_FN_FOURTH)) begin
      rd_word = {8'h00, out_fn_ff[reg_addr[1:0] - 2'd1]};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rd_data  <= `RST_WORD;
      reg_rd_valid <= 1'b0;
      fb_rd_data   <= `RST_WORD;
      fb_rd_valid  <= 1'b0;
      fb_rd_error  <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_word;
      end
      fb_rd_valid <= fb_rd_en;
      fb_rd_error <= 1'b0;
      if (fb_rd_en) begin
        if ((fb_index == `FB_INDEX_COUNT) && (fb_subindex == `FB_SUBINDEX_COUNT)) begin
          fb_rd_data <= count_ff;
        end else begin
          fb_rd_data  <= `RST_WORD;
          fb_rd_error <= 1'b1;
        end
      end
    end
  end

endmodule // terminal_event_counter_io

module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Raw pins and their synchronised copy
  input  wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] pin_synced
);

  // Only the second stage leaves, so no logic sees a metastable level
  reg  [WIDTH-1:0] meta_ff;
  reg  [WIDTH-1:0] sync_ff;

  always @(posedge ref_clk) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= pin_async;
      sync_ff <= meta_ff;
    end
  end

  assign pin_synced = sync_ff;

endmodule // pin_sync

module out_drive (
  // Configuration
  input  wire [7:0] fn_code,
  input  wire       invert,
  // Counter flags
  input  wire       term_hit,
  input  wire       prelim_hit,
  // Pin level after polarity
  output wire       level
);

  wire              active;

  // Codes other than the two counter ones leave the output off here
  assign active = ((fn_code == `FN_TERMINAL_REACHED) && term_hit) ||
                  ((fn_code == `FN_PRELIM_REACHED) && prelim_hit);
  assign level  = active ^ invert;

endmodule // out_drive

// ---- test/counter_sva.sv ----
`timescale 1ns/10ps
module counter_sva (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Pins
  input wire [5:0]  input_terminal,
  // Register port
  input wire        reg_rd_en,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_rd_data,
  input wire        reg_rd_valid,
  // Fieldbus port
  input wire        fb_rd_en,
  input wire [15:0] fb_index,
  input wire [7:0]  fb_subindex,
  input wire [15:0] fb_rd_data,
  input wire        fb_rd_valid,
  input wire        fb_rd_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid) else $error("no read answer");
  rd_hold_a: assert property (!reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data)) else $error("read moved");
  fb_answer_a: assert property (fb_rd_en |=> fb_rd_valid) else $error("no fb answer");
  fb_hold_a: assert property (!fb_rd_en |=> !fb_rd_valid && $stable(fb_rd_data)) else $error("fb moved");
  fb_bad_a:
    assert property (fb_rd_en && (fb_index != 16'h2022 || fb_subindex != 8'h02) |=> fb_rd_error && fb_rd_data == 16'h0)
    else $error("fb bad object");
  fb_good_a: assert property (fb_rd_en && fb_index == 16'h2022 && fb_subindex == 8'h02 |=> !fb_rd_error)
    else $error("fb good object");
  in_map_a:
    assert property ($stable(input_terminal)[*4] ##0 (reg_rd_en && reg_addr == 16'h0232)
      |=> reg_rd_data == {10'h000, $past(input_terminal)}) else $error("input map");
  out_map_a: assert property (reg_rd_en && reg_addr == 16'h0233 |=> reg_rd_data[15:4] == 12'h000)
    else $error("output map");
endmodule // counter_sva
bind terminal_event_counter_io counter_sva u_sva (.ref_clk(ref_clk), .rst(rst), .input_terminal(input_terminal),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .fb_rd_en(fb_rd_en), .fb_index(fb_index), .fb_subindex(fb_subindex), .fb_rd_data(fb_rd_data),
  .fb_rd_valid(fb_rd_valid), .fb_rd_error(fb_rd_error));

// ---- test/field_switches.sv ----
`timescale 1ns/10ps
module field_switches (
  // Switch commands and pins
  input wire [5:0]  cmd,
  output wire [5:0] pins
);
  // Clean contacts, so pins follow the command
  assign pins = cmd;
endmodule // field_switches

// ---- test/terminal_event_counter_io_tb.sv ----
`timescale 1ns/10ps
module terminal_event_counter_io_tb;
  logic        ref_clk, rst, wr, rd, fbe;
  logic [15:0] addr, wd, fbi;
  logic [7:0]  fbs;
  logic [5:0]  sw;
  wire  [5:0]  pins;
  wire  [3:0]  outs;
  wire  [15:0] rdat, fdat;
  wire         rval, fval, ferr;
  int          miscompares, tests_run;
  field_switches sw_u (.cmd(sw), .pins(pins));
  terminal_event_counter_io DUT (.ref_clk(ref_clk), .rst(rst), .input_terminal(pins), .output_terminal(outs),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wr_data(wd), .reg_rd_data(rdat), .reg_rd_valid(rval),
    .fb_rd_en(fbe), .fb_index(fbi), .fb_subindex(fbs), .fb_rd_data(fdat), .fb_rd_valid(fval),
    .fb_rd_error(ferr));
  task chk(input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrr(input logic [15:0] a, d);
    wr = 1'b1; addr = a; wd = d;
    @(negedge ref_clk) wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task rdr(input logic [15:0] a, e);
    rd = 1'b1; addr = a;
    @(negedge ref_clk) rd = 1'b0;
    chk({15'h0, rval}, 16'h1);
    chk(rdat, e);
    @(negedge ref_clk);
  endtask
  task fbr(input logic [15:0] e, x, input logic [7:0] s);
    fbe = 1'b1; fbi = x; fbs = s;
    @(negedge ref_clk) fbe = 1'b0;
    chk({15'h0, fval}, 16'h1);
    chk({15'h0, ferr}, {15'h0, (x != 16'h2022) || (s != 8'h02)});
    chk(fdat, e);
    @(negedge ref_clk);
  endtask
  // Toggles sit six cycles apart, past sync and output latency
  task tg;
    sw[5] = ~sw[5];
    repeat (6) @(negedge ref_clk);
  endtask
  task end_of_test;
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; fbe = 1'b0;
    addr = 16'h0; wd = 16'h0; fbs = 8'h02; fbi = 16'h2022; sw = 6'h00;
    miscompares = 0; tests_run = 0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rdr(16'h0212, 16'h0000);
    rdr(16'h0213, 16'h0000);
    rdr(16'h0214, 16'h0000);
    sw = 6'h14;
    repeat (3) @(negedge ref_clk);
    rdr(16'h0232, 16'h0014);
    sw = 6'h00;
    wrr(16'h0206, 16'h0017);
    wrr(16'h020D, 16'h0012);
    wrr(16'h020E, 16'h0011);
    wrr(16'h0212, 16'h0004);
    @(negedge ref_clk);
    chk({12'h0, outs}, 16'h0004);
    tg;
    rdr(16'h2109, 16'h0000);
    wrr(16'h0213, 16'h0003);
    wrr(16'h0214, 16'h0002);
    tg;
    rdr(16'h2109, 16'h0001);
    fbr(16'h0001, 16'h2022, 8'h02);
    fbr(16'h0000, 16'h2023, 8'h02);
    tg;
    chk({12'h0, outs}, 16'h0006);
    rdr(16'h0233, 16'h0002);
    tg;
    chk({12'h0, outs}, 16'h0005);
    rdr(16'h2109, 16'h0000);
    wrr(16'h0201, 16'h0016);
    tg;
    sw[0] = 1'b1;
    repeat (4) @(negedge ref_clk);
    rdr(16'h2109, 16'h0000);
    fbr(16'h0000, 16'h2022, 8'h03);
    end_of_test;
  end
endmodule // terminal_event_counter_io_tb
